// ---- hdl/acs_result_format.sv ----
// Purpose: Places a raw conversion code into the 16-bit result word
// Assumes: A 10-bit code arrives in raw; 8-bit results take its top eight bits
// Notes:   One cycle of latency from in_valid to out_valid
`timescale 1ns/100ps
`default_nettype none
module acs_result_format (
	input  wire logic               clk,
	input  wire logic               reset,
	input  wire logic               in_valid,
	input  wire logic [9:0]         raw,
	input  wire logic [2:0]         slot,
	input  wire logic               low_res,
	input  wire logic               justify_right,
	input  wire logic               signed_sel,
	output logic                    out_valid,
	output acs_pkg::acs_result_t    result
);
	logic [15:0] next_data;

	always_comb begin
		next_data = 16'h0000;
		if (justify_right) begin
			// Signed select has no effect here
			if (low_res) next_data = {8'h00, raw[9:2]};
			else         next_data = {6'h00, raw};
		end else begin
			if (low_res) next_data = {raw[9:2], 8'h00};
			else         next_data = {raw, 6'h00};
			if (signed_sel) next_data[15] = ~next_data[15];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			out_valid <= 1'b0;
			result    <= '0;
		end else begin
			out_valid <= in_valid;
			if (in_valid) begin
				result.data <= next_data;
				result.slot <= slot;
			end
		end
	end

	a_right_unsigned : assert property (@(posedge clk) disable iff (reset)
		in_valid && justify_right |=> out_valid && result.data[15:10] == 6'h00)
		else $error("right justified result has high bits set");

	a_signed_invert : assert property (@(posedge clk) disable iff (reset)
		in_valid && !justify_right && signed_sel |=>
		result.data[15] == ~$past(raw[9]))
		else $error("signed result top bit not inverted");

	a_left_low_zero : assert property (@(posedge clk) disable iff (reset)
		in_valid && !justify_right && low_res |=> result.data[7:0] == 8'h00)
		else $error("8-bit left result has low byte set");
endmodule : acs_result_format
`default_nettype wire

// ---- hdl/acs_result_mem.sv ----
// Purpose: Eight result slots of sixteen bits
// Assumes: One write port and one read port
// Notes:   Read data come from a register one cycle after the address
`timescale 1ns/100ps
`default_nettype none
module acs_result_mem (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        wr_en,
	input  wire logic [2:0]  wr_slot,
	input  wire logic [15:0] wr_data,
	input  wire logic [2:0]  rd_slot,
	output logic      [15:0] rd_data
);
	logic [15:0] slots [8];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			slots[wr_slot] <= wr_data;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd_data <= 16'h0000;
		end else begin
			rd_data <= slots[rd_slot];
		end
	end
endmodule : acs_result_mem
`default_nettype wire

// ---- hdl/acs_seq_control.sv ----
// Purpose: Conversion sequence control with result placement and slot storage
// Assumes: Converter answers each conv_start with one conv_done pulse
// Notes:   A control write while a result is pending drops that result
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module acs_seq_control (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [6:0]  address,
	input  wire logic [3:0]  byteenable,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	output logic             conv_start,
	output logic             conv_abort,
	output logic      [2:0]  conv_channel,
	output logic             conv_low_res,
	input  wire logic        conv_done,
	input  wire logic [9:0]  conv_data
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	acs_pkg::acs_seq_ctl_t   ctl;
	logic [7:0]              cfg;
	acs_pkg::acs_seq_state_t state;
	logic [2:0]              conv_index;
	logic [2:0]              result_slot_counter;
	logic                    complete;
	logic [1:0]              rd_cnt;
	logic [15:0]             slot_rd_data;
	logic                    fmt_valid;
	acs_pkg::acs_result_t    fmt_result;
	logic [31:0]             next_readdata;
	logic [2:0]              len_m1;
	logic                    sel_ctl;
	logic                    sel_cfg;
	logic                    sel_stat;
	logic                    sel_slot;
	logic                    ctl_write;
	logic                    done_ok;
	logic                    last_conv;
	acs_pkg::acs_seq_ctl_t   wr_ctl;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign sel_ctl   = address[6:2] == acs_pkg::CTL_INDEX;
	assign sel_cfg   = address[6:2] == acs_pkg::CFG_INDEX;
	assign sel_stat  = address[6:2] == acs_pkg::STAT_INDEX;
	assign sel_slot  = address[6:5] == acs_pkg::SLOT_BASE_INDEX[4:3];
	// Writes are taken in any state, no lockout
	assign ctl_write = write && sel_ctl && byteenable[0];
	assign wr_ctl    = acs_pkg::acs_seq_ctl_t'(writedata[7:0]);

	// Every read waits so the slot memory read register can settle
	assign waitrequest = read && (rd_cnt != acs_pkg::RD_WAIT_CYCLES);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd_cnt <= 2'h0;
		end else if (read && waitrequest) begin
			rd_cnt <= rd_cnt + 2'h1;
		end else begin
			rd_cnt <= 2'h0;
		end
	end

	always_comb begin
		next_readdata = 32'h0000_0000;
		if (sel_ctl) begin
			next_readdata[7:0] = ctl;
		end else if (sel_cfg) begin
			next_readdata[7:0] = cfg;
		end else if (sel_stat) begin
			next_readdata[acs_pkg::STAT_COMPLETE_BIT]           = complete;
			next_readdata[acs_pkg::STAT_ACTIVE_BIT]             = state != acs_pkg::SEQ_IDLE;
			next_readdata[acs_pkg::STAT_SLOT_LSB +: 3]          = result_slot_counter;
		end else if (sel_slot) begin
			next_readdata[15:0] = slot_rd_data;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			readdata <= 32'h0000_0000;
		end else if (read && rd_cnt == 2'h1) begin
			readdata <= next_readdata;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctl <= acs_pkg::acs_seq_ctl_t'(acs_pkg::CTL_RESET);
		end else if (ctl_write) begin
			ctl          <= wr_ctl;
			ctl.reserved <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cfg <= acs_pkg::CFG_RESET;
		end else if (write && sel_cfg && byteenable[0]) begin
			cfg <= writedata[7:0];
		end
	end

	assign conv_low_res = cfg[acs_pkg::CFG_LOWRES_BIT];

	// Length 0 and anything above 8 both mean 8 conversions
	always_comb begin
		len_m1 = 3'h7;
		if (cfg[acs_pkg::CFG_LEN_LSB +: 4] != 4'h0 && cfg[acs_pkg::CFG_LEN_LSB +: 4] < 4'h8) begin
			len_m1 = 3'(cfg[acs_pkg::CFG_LEN_LSB +: 4] - 4'h1);
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// A done arriving with a control write belongs to the aborted sequence
	assign done_ok   = conv_done && state == acs_pkg::SEQ_WAIT && !ctl_write;
	assign last_conv = conv_index == len_m1;
	assign conv_start = state == acs_pkg::SEQ_ISSUE;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			conv_abort <= 1'b0;
		end else begin
			conv_abort <= ctl_write && state != acs_pkg::SEQ_IDLE;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= acs_pkg::SEQ_IDLE;
		end else if (ctl_write) begin
			state <= acs_pkg::SEQ_ISSUE;
		end else begin
			unique case (state)
				acs_pkg::SEQ_IDLE: begin
					state <= acs_pkg::SEQ_IDLE;
				end
				acs_pkg::SEQ_ISSUE: begin
					state <= acs_pkg::SEQ_WAIT;
				end
				acs_pkg::SEQ_WAIT: begin
					if (done_ok && last_conv && !ctl.continuous_scan) begin
						state <= acs_pkg::SEQ_IDLE;
					end else if (done_ok) begin
						state <= acs_pkg::SEQ_ISSUE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			conv_index <= 3'h0;
		end else if (ctl_write || (done_ok && last_conv)) begin
			conv_index <= 3'h0;
		end else if (done_ok) begin
			conv_index <= conv_index + 3'h1;
		end
	end

	// Code n addresses input channel n directly
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			conv_channel <= 3'h0;
		end else if (ctl_write) begin
			conv_channel <= wr_ctl.channel_code;
		end else if (done_ok && last_conv) begin
			conv_channel <= ctl.channel_code;
		end else if (done_ok && ctl.multi_channel_enable) begin
			conv_channel <= conv_channel + 3'h1;
		end else if (done_ok) begin
			conv_channel <= ctl.channel_code;
		end
	end

	// Slot counter wraps in three bits and restarts with each sequence
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			result_slot_counter <= 3'h0;
		end else if (ctl_write || (done_ok && last_conv)) begin
			result_slot_counter <= 3'h0;
		end else if (done_ok) begin
			result_slot_counter <= result_slot_counter + 3'h1;
		end
	end

	// Completion is set before a write-one clear is honoured
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			complete <= 1'b0;
		end else if (done_ok && last_conv) begin
			complete <= 1'b1;
		end else if (ctl_write) begin
			complete <= 1'b0;
		end else if (write && sel_stat && byteenable[0] && writedata[acs_pkg::STAT_COMPLETE_BIT]) begin
			complete <= 1'b0;
		end
	end

	// ----------------------------------------
	// Result path
	// ----------------------------------------
	acs_result_format u_format (
		.clk           (clk),
		.reset         (reset),
		.in_valid      (done_ok),
		.raw           (conv_data),
		.slot          (result_slot_counter),
		.low_res       (conv_low_res),
		.justify_right (ctl.result_justify_right),
		.signed_sel    (ctl.result_signed_select),
		.out_valid     (fmt_valid),
		.result        (fmt_result)
	);

	acs_result_mem u_mem (
		.clk     (clk),
		.reset   (reset),
		.wr_en   (fmt_valid),
		.wr_slot (fmt_result.slot),
		.wr_data (fmt_result.data),
		.rd_slot (address[4:2]),
		.rd_data (slot_rd_data)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_ctl_write;
		ctl_write;
	endsequence

	sequence s_restart;
		state == acs_pkg::SEQ_ISSUE && conv_index == 3'h0 && conv_start;
	endsequence

	sequence s_read_wait;
		waitrequest ##1 waitrequest ##1 !waitrequest;
	endsequence

	a_write_restart : assert property (@(posedge clk) disable iff (reset)
		s_ctl_write |=> s_restart)
		else $error("control write did not restart the sequence");

	a_slot_cleared : assert property (@(posedge clk) disable iff (reset)
		s_ctl_write |=> result_slot_counter == 3'h0 && !complete)
		else $error("control write did not clear the slot counter");

	a_single_channel : assert property (@(posedge clk) disable iff (reset)
		conv_start && !ctl.multi_channel_enable |-> conv_channel == ctl.channel_code)
		else $error("single channel mode sampled another channel");

	a_multi_advance : assert property (@(posedge clk) disable iff (reset)
		done_ok && !last_conv && ctl.multi_channel_enable |=>
		conv_start && conv_channel == $past(conv_channel) + 3'h1)
		else $error("multi channel code did not advance by one");

	a_single_stop : assert property (@(posedge clk) disable iff (reset)
		done_ok && last_conv && !ctl.continuous_scan |=>
		state == acs_pkg::SEQ_IDLE && complete)
		else $error("single sequence did not stop");

	a_scan_repeat : assert property (@(posedge clk) disable iff (reset)
		done_ok && last_conv && ctl.continuous_scan |=>
		conv_start && conv_channel == ctl.channel_code)
		else $error("continuous sequence did not repeat");

	a_read_answer : assert property (@(posedge clk) disable iff (reset)
		read && rd_cnt == 2'h0 && !$past(read) |-> s_read_wait)
		else $error("read not answered on the third cycle");

	a_result_store : assert property (@(posedge clk) disable iff (reset)
		done_ok && !ctl.result_justify_right && !conv_low_res && !ctl.result_signed_select
		|=> fmt_valid && fmt_result.data == {$past(conv_data), 6'h00})
		else $error("10-bit left result misplaced");

	sequence s_result_next;
		fmt_valid;
	endsequence

	a_abort_pulse : assert property (@(posedge clk) disable iff (reset)
		ctl_write && state != acs_pkg::SEQ_IDLE |=> conv_abort)
		else $error("control write did not abort the running sequence");

	a_abort_quiet : assert property (@(posedge clk) disable iff (reset)
		!ctl_write |=> !conv_abort)
		else $error("abort raised without a control write");

	a_channel_load : assert property (@(posedge clk) disable iff (reset)
		ctl_write |=> conv_channel == $past(writedata[2:0]))
		else $error("new channel code not applied");

	a_ctl_capture : assert property (@(posedge clk) disable iff (reset)
		ctl_write |=> ctl.reserved == 1'b0 && ctl.result_justify_right == $past(writedata[7]))
		else $error("control write not captured");

	a_single_hold : assert property (@(posedge clk) disable iff (reset)
		done_ok && !ctl.multi_channel_enable |=> conv_channel == ctl.channel_code)
		else $error("single channel code not kept");

	a_complete_wins : assert property (@(posedge clk) disable iff (reset)
		done_ok && last_conv |=> complete)
		else $error("sequence end did not set completion");

	a_slot_advance : assert property (@(posedge clk) disable iff (reset)
		done_ok && !last_conv |=> result_slot_counter == $past(result_slot_counter) + 3'h1)
		else $error("slot counter did not advance");

	a_left8_store : assert property (@(posedge clk) disable iff (reset)
		done_ok && !ctl.result_justify_right && conv_low_res && !ctl.result_signed_select
		|=> s_result_next ##0 fmt_result.data == {$past(conv_data[9:2]), 8'h00})
		else $error("8-bit left result misplaced");

	a_right8_store : assert property (@(posedge clk) disable iff (reset)
		done_ok && ctl.result_justify_right && conv_low_res
		|=> s_result_next ##0 fmt_result.data == {8'h00, $past(conv_data[9:2])})
		else $error("8-bit right result misplaced");

	a_right10_store : assert property (@(posedge clk) disable iff (reset)
		done_ok && ctl.result_justify_right && !conv_low_res
		|=> s_result_next ##0 fmt_result.data == {6'h00, $past(conv_data)})
		else $error("10-bit right result misplaced");

	a_signed_store : assert property (@(posedge clk) disable iff (reset)
		done_ok && !ctl.result_justify_right && !conv_low_res && ctl.result_signed_select |=>
		s_result_next ##0 fmt_result.data[15] == ~$past(conv_data[9]) &&
		fmt_result.data[14:0] == {$past(conv_data[8:0]), 6'h00})
		else $error("signed result not formed from unsigned code");

	a_read_ctl : assert property (@(posedge clk) disable iff (reset)
		read && !waitrequest && sel_ctl |-> readdata[7:0] == ctl)
		else $error("control readback differs from register");

endmodule : acs_seq_control
`default_nettype wire

// ---- pkg/acs_pkg.sv ----
// Purpose: Shared constants and types of the conversion sequence control block
// Assumes: Registers are reached over Avalon-MM, one 32-bit word per register index
// Notes:   Byte address of a register is its index times four
package acs_pkg;

	// ----------------------------------------
	// Register indices
	// ----------------------------------------
	localparam logic [4:0] CFG_INDEX       = 5'h04;
	localparam logic [4:0] CTL_INDEX       = 5'h05;
	localparam logic [4:0] STAT_INDEX      = 5'h06;
	localparam logic [4:0] SLOT_BASE_INDEX = 5'h10;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int         CFG_LOWRES_BIT    = 7;
	localparam int         CFG_LEN_LSB       = 0;
	localparam int         STAT_COMPLETE_BIT = 7;
	localparam int         STAT_ACTIVE_BIT   = 6;
	localparam int         STAT_SLOT_LSB     = 0;
	localparam logic [7:0] CTL_RESET         = 8'h00;
	localparam logic [7:0] CFG_RESET         = 8'h00;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam logic [1:0] RD_WAIT_CYCLES = 2'h2;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic       result_justify_right;
		logic       result_signed_select;
		logic       continuous_scan;
		logic       multi_channel_enable;
		logic       reserved;
		logic [2:0] channel_code;
	} acs_seq_ctl_t;

	typedef struct packed {
		logic [2:0]  slot;
		logic [15:0] data;
	} acs_result_t;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_ISSUE,
		SEQ_WAIT
	} acs_seq_state_t;

endpackage : acs_pkg

// ---- verif/adc_sequence_setup_and_result_format_test.sv ----
// Purpose: Self-checking bench of the conversion sequence control block
// Assumes: Bench plays both the bus master and the converter
// Notes:   Converter outputs are looked at on the falling edge; bus answers at the rising edge
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
	$display("Error at %0t: got %h expected %h", $time, a, b); end end
module adc_sequence_setup_and_result_format_test;
	logic        clk;
	logic        reset;
	logic [6:0]  address;
	logic [3:0]  byteenable;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        conv_start;
	logic        conv_abort;
	logic [2:0]  conv_channel;
	logic        conv_low_res;
	logic        conv_done;
	logic [9:0]  conv_data;
	int          failures;
	int          n_compared;
	localparam logic [6:0] CFG_A  = {acs_pkg::CFG_INDEX, 2'b00};
	localparam logic [6:0] CTL_A  = {acs_pkg::CTL_INDEX, 2'b00};
	localparam logic [6:0] STAT_A = {acs_pkg::STAT_INDEX, 2'b00};
	localparam logic [6:0] SLOT_A = {acs_pkg::SLOT_BASE_INDEX, 2'b00};

	acs_seq_control dut_u (
		.clk          (clk),
		.reset        (reset),
		.address      (address),
		.byteenable   (byteenable),
		.read         (read),
		.write        (write),
		.writedata    (writedata),
		.readdata     (readdata),
		.waitrequest  (waitrequest),
		.conv_start   (conv_start),
		.conv_abort   (conv_abort),
		.conv_channel (conv_channel),
		.conv_low_res (conv_low_res),
		.conv_done    (conv_done),
		.conv_data    (conv_data)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------
	// Bus and converter tasks
	// ----------------------------------------
	// Request holds until the rising edge that samples waitrequest low; data taken there
	task automatic bus(input logic we, input logic [6:0] a, input logic [7:0] wd,
			output logic [31:0] rd);
		int k;
		k = 0;
		@(posedge clk);
		address   <= a;
		writedata <= {24'h00_0000, wd};
		write     <= we;
		read      <= ~we;
		do begin
			@(posedge clk);
			k++;
		end while (waitrequest !== 1'b0 && k < 20);
		`CHK(waitrequest, 1'b0)
		rd = readdata;
		write     <= 1'b0;
		read      <= 1'b0;
		writedata <= 32'hA5A5_A5A5;
	endtask : bus

	task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp);
		logic [31:0] d;
		bus(1'b0, a, 8'h00, d);
		`CHK(d, exp)
	endtask : rd_chk

	task automatic wr(input logic [6:0] a, input logic [7:0] wd);
		logic [31:0] d;
		bus(1'b1, a, wd, d);
	endtask : wr

	// Waits for a start, checks the channel, answers two cycles later
	task automatic conv(input logic [2:0] ch, input logic [9:0] raw);
		int k;
		k = 0;
		// A start already showing at a falling edge is taken at once
		while (conv_start !== 1'b1 && k < 50) begin
			@(negedge clk);
			k++;
		end
		`CHK(conv_start, 1'b1)
		`CHK(conv_channel, ch)
		@(posedge clk);
		@(posedge clk);
		conv_done <= 1'b1;
		conv_data <= raw;
		@(posedge clk);
		conv_done <= 1'b0;
		conv_data <= ~raw;
	endtask : conv

	task automatic no_start();
		repeat (6) begin
			@(negedge clk);
			`CHK(conv_start, 1'b0)
		end
	endtask : no_start

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd_chk(CTL_A, 32'h0000_0000);
		rd_chk(CFG_A, 32'h0000_0000);
		rd_chk(7'h7C, 32'h0000_0000);
		wr(CTL_A, 8'hFF);
		conv(3'h7, 10'h000);
		rd_chk(CTL_A, 32'h0000_00F7);
		$display("reset values and readback done");
	endtask : t_reset

	// Every resolution, justification and coding with mid-scale and a high code
	task automatic t_formats();
		logic [9:0]  r;
		logic [15:0] e;
		logic [2:0]  ch;
		logic        lo;
		logic        jr;
		logic        sg;
		for (int i = 0; i < 16; i++) begin
			{lo, jr, sg} = i[2:0];
			r  = i[3] ? 10'h3F1 : 10'h200;
			ch = 3'(i % 8);
			if (lo)
				e = jr ? {8'h00, r[9:2]} : {r[9:2], 8'h00};
			else
				e = jr ? {6'h00, r} : {r, 6'h00};
			if (sg && !jr)
				e[15] = ~e[15];
			wr(CFG_A, {lo, 7'h01});
			wr(CTL_A, {jr, sg, 3'h0, ch});
			@(negedge clk);
			`CHK(conv_low_res, lo)
			conv(ch, r);
			// The result lands in the slot two edges after the done
			repeat (2) @(posedge clk);
			rd_chk(SLOT_A, {16'h0000, e});
		end
		rd_chk(STAT_A, 32'h0000_0080);
		$display("result formats done");
	endtask : t_formats

	task automatic t_multi_wrap();
		wr(CFG_A, 8'h04);
		wr(CTL_A, 8'h16);
		conv(3'h6, 10'h011);
		conv(3'h7, 10'h022);
		conv(3'h0, 10'h033);
		conv(3'h1, 10'h044);
		no_start();
		rd_chk(SLOT_A + 7'h0C, 32'h0000_1100);
		rd_chk(SLOT_A + 7'h08, 32'h0000_0CC0);
		$display("multi channel wrap done");
	endtask : t_multi_wrap

	task automatic t_abort();
		wr(CFG_A, 8'h03);
		wr(CTL_A, 8'h15);
		conv(3'h5, 10'h100);
		conv(3'h6, 10'h101);
		rd_chk(STAT_A, 32'h0000_0042);
		wr(CTL_A, 8'h81);
		@(negedge clk);
		`CHK(conv_abort, 1'b1)
		rd_chk(STAT_A, 32'h0000_0040);
		// The start went by during the read, so a second write restarts the sequence
		wr(CTL_A, 8'h81);
		conv(3'h1, 10'h155);
		conv(3'h1, 10'h156);
		conv(3'h1, 10'h157);
		no_start();
		rd_chk(SLOT_A + 7'h08, 32'h0000_0157);
		$display("abort and restart done");
	endtask : t_abort

	task automatic t_continuous();
		wr(CFG_A, 8'h02);
		wr(CTL_A, 8'h33);
		repeat (2) begin
			conv(3'h3, 10'h0F0);
			conv(3'h4, 10'h0F1);
		end
		rd_chk(STAT_A, 32'h0000_00C0);
		wr(CTL_A, 8'h00);
		conv(3'h0, 10'h001);
		conv(3'h0, 10'h002);
		no_start();
		$display("continuous sequences done");
	endtask : t_continuous

	// ----------------------------------------
	// Closing and main sequence
	// ----------------------------------------
	task automatic results();
		$display("compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		results();
	end

	initial begin
		failures   = 0;
		n_compared = 0;
		reset      = 1'b1;
		address    = 7'h00;
		byteenable = 4'h1;
		read       = 1'b0;
		write      = 1'b0;
		writedata  = 32'h0000_0000;
		conv_done  = 1'b0;
		conv_data  = 10'h000;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_formats();
		t_multi_wrap();
		t_abort();
		t_continuous();
		results();
	end
endmodule : adc_sequence_setup_and_result_format_test
`default_nettype wire
